// ===== clkctl_regs.svh
// register map, field positions, reset values and counts of the clock controller
`ifndef CLKCTL_REGS_SVH
`define CLKCTL_REGS_SVH

// -----------------------------------------------------------------------------
// register index (byte address is four times the index)
// -----------------------------------------------------------------------------
`define CCS_INDEX        10'h02E
`define CCS_RESET        8'h00
`define CCS_WMASK        8'hFE
`define APB_ADDR_W       12
`define APB_RDATA_ZERO   32'h0000_0000

// -----------------------------------------------------------------------------
// field positions of clock_control_status
// -----------------------------------------------------------------------------
`define BIT_CLKOUT       7
`define FLD_DIV_HI       6
`define FLD_DIV_LO       5
`define BIT_SLOW         4
`define FLD_TB_HI        3
`define FLD_TB_LO        2
`define BIT_TIE          1
`define BIT_FLAG         0

// -----------------------------------------------------------------------------
// time-base periods in oscillator cycles
// -----------------------------------------------------------------------------
`define TB_PERIOD_00     18'h03E80
`define TB_PERIOD_01     18'h07D00
`define TB_PERIOD_10     18'h13880
`define TB_PERIOD_11     18'h30D40
`define TB_CNT_W         18

// -----------------------------------------------------------------------------
// slow-mode divider
// -----------------------------------------------------------------------------
`define DIV_CNT_W        4
`define DIV_MASK_2       4'h1
`define DIV_MASK_4       4'h3
`define DIV_MASK_8       4'h7
`define DIV_MASK_16      4'hF

`endif

// ===== clkctl_pkg.sv
// types shared by the clock controller files
package clkctl_pkg;

  // power modes, gray coded along run -> wait -> active halt -> halt
  typedef enum logic [1:0] {
    PM_RUN         = 2'h0,
    PM_WAIT        = 2'h1,
    PM_ACTIVE_HALT = 2'h3,
    PM_HALT        = 2'h2
  } pwr_mode_t;

  // clock_control_status layout, msb first
  typedef struct packed {
    logic       clock_out_enable;
    logic [1:0] slow_divider_select;
    logic       slow_speed_select;
    logic [1:0] period_select;
    logic       tick_irq_enable;
    logic       tick_flag;
  } ccs_t;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

// ===== core_clk_div.sv
// slow-mode divider producing the core clock enable
`timescale 1ns/1ps
`include "clkctl_regs.svh"

module core_clk_div (
  input  wire logic       clk,        // oscillator clock
  input  wire logic       rst,        // async reset, active high
  input  wire logic       ce,         // global clock enable
  input  wire logic       run,        // low stops the core clock
  input  wire logic       slow,       // slow mode select
  input  wire logic [1:0] div_sel,    // slow divider select
  output logic            core_en     // one-cycle core clock enable
);

  logic [`DIV_CNT_W-1:0] cnt_ff;
  logic [`DIV_CNT_W-1:0] div_mask;
  logic                  div_hit;
  logic                  nxt_core_en;

  // -----------------------------------------------------------------------------
  // divide selection
  // -----------------------------------------------------------------------------
  assign div_mask    = (div_sel == 2'h0) ? `DIV_MASK_2 :
                       (div_sel == 2'h1) ? `DIV_MASK_4 :
                       (div_sel == 2'h2) ? `DIV_MASK_8 : `DIV_MASK_16;
  assign div_hit     = (cnt_ff & div_mask) == div_mask;
  assign nxt_core_en = run & (~slow | div_hit);

  // free counter and registered enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff  <= '0;
      core_en <= 1'b0;
    end else if (ce) begin
      cnt_ff  <= cnt_ff + 1'b1;
      core_en <= nxt_core_en;
    end
  end

endmodule // core_clk_div

// ===== clock_prescaler_rtc_tick.sv
// main clock controller: core clock prescaler, clock-out select, time-base tick
//
// Contract
// - clock-out bit routes oscillator clock to pin
// - slow bit divides core clock by 2..16
// - period field picks 16000..200000 cycle period
// - new period applies after current period ends
// - period end sets flag; register read clears
// - interrupt while flag and enable both set
// - halt with enable set enters active halt unless auto-wake halt is selected
// - wait keeps counting; tick wakes from wait
// - active halt counts, registers frozen, tick wakes; the tick flag is still set by the time base here
// - halt freezes all; only other interrupts wake
// - reset clears the register to zero
// - prescaler, clock-out, time base run independently
`timescale 1ns/1ps
`include "clkctl_regs.svh"

module clock_prescaler_rtc_tick #(
  parameter logic [`TB_CNT_W-1:0] PERIOD_00 = `TB_PERIOD_00,  // cycles for code 00
  parameter logic [`TB_CNT_W-1:0] PERIOD_01 = `TB_PERIOD_01,  // cycles for code 01
  parameter logic [`TB_CNT_W-1:0] PERIOD_10 = `TB_PERIOD_10,  // cycles for code 10
  parameter logic [`TB_CNT_W-1:0] PERIOD_11 = `TB_PERIOD_11   // cycles for code 11
) (
  input  wire logic                  SYS_CLK,     // oscillator clock, 100 MHz
  input  wire logic                  RST,         // async reset, active high
  input  wire logic                  CE,          // clock enable, low freezes all
  input  wire logic                  PSEL,        // apb select
  input  wire logic                  PENABLE,     // apb enable
  input  wire logic                  PWRITE,      // apb direction
  input  wire logic [11:0]           PADDR,       // apb byte address
  input  wire logic [31:0]           PWDATA,      // apb write data
  output logic      [31:0]           PRDATA,      // apb read data
  output logic                       PREADY,      // apb ready
  output logic                       PSLVERR,     // apb error, unmapped address
  input  wire logic                  WAIT_REQ,    // core executed wait, pulse
  input  wire logic                  HALT_REQ,    // core executed halt, pulse
  input  wire logic                  AWU_SEL,     // halt request is auto-wake halt
  input  wire logic                  EXT_WAKE,    // other halt-exit interrupt, level
  output logic                       CORE_CLK_EN, // core clock enable pulse
  output logic                       CLKOUT_SEL,  // pin takes oscillator clock
  output logic                       TICK_IRQ,    // tick interrupt request
  output clkctl_pkg::pwr_mode_t      PWR_MODE     // current power mode
);

  import clkctl_pkg::*;

  // -----------------------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------------------
  apb_req_t                 req;
  ccs_t                     ccs_ff;
  ccs_t                     nxt_ccs;
  pwr_mode_t                mode_ff;
  pwr_mode_t                nxt_mode;
  logic [`TB_CNT_W-1:0]     tb_cnt_ff;
  logic [`TB_CNT_W-1:0]     nxt_tb_cnt;
  logic [`TB_CNT_W-1:0]     tb_len_ff;
  logic [`TB_CNT_W-1:0]     nxt_tb_len;
  logic [`TB_CNT_W-1:0]     sel_len;
  logic [31:0]              prdata_ff;
  logic [31:0]              nxt_prdata;
  logic                     pready_ff;
  logic                     pslverr_ff;
  logic                     irq_ff;
  logic                     clkout_ff;
  logic                     hit;
  logic                     setup;
  logic                     done;
  logic                     wr_ok;
  logic                     rd_clr;
  logic                     tb_end;
  logic                     tb_run;
  logic                     regs_live;
  logic                     core_run;
  logic                     core_en;
  logic [7:0]               wr_byte;
  logic [7:0]               ccs_bits;

  // -----------------------------------------------------------------------------
  // apb decode
  // -----------------------------------------------------------------------------
  // carry the bus inputs together
  assign req       = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE,
                       paddr: PADDR, pwdata: PWDATA};
  assign hit       = (req.paddr[11:2] == `CCS_INDEX) & (req.paddr[1:0] == 2'h0);
  assign setup     = req.psel & ~req.penable;
  // access completes at the edge where pready is seen high
  assign done      = req.psel & req.penable & pready_ff;
  assign ccs_bits  = ccs_ff;
  assign wr_byte   = req.pwdata[7:0];
  // bus writes and read clears are ignored in both halt modes; the tick can still set the flag in active halt
  assign regs_live = (mode_ff == PM_RUN) | (mode_ff == PM_WAIT);
  assign wr_ok     = done & req.pwrite & hit & regs_live;
  // clear only a flag that the read actually returned, so a late set survives
  assign rd_clr    = done & ~req.pwrite & hit & regs_live & prdata_ff[`BIT_FLAG];
  // read data captured in the setup cycle, zero when unmapped
  assign nxt_prdata = (setup & ~req.pwrite & hit) ? {24'h00_0000, ccs_bits}
                                                  : `APB_RDATA_ZERO;

  // -----------------------------------------------------------------------------
  // time-base counter
  // -----------------------------------------------------------------------------
  // period lookup from the period field
  assign sel_len = (ccs_ff.period_select == 2'h0) ? PERIOD_00 :
                   (ccs_ff.period_select == 2'h1) ? PERIOD_01 :
                   (ccs_ff.period_select == 2'h2) ? PERIOD_10 : PERIOD_11;
  // counter stops only in full and auto-wake halt
  assign tb_run     = (mode_ff != PM_HALT);
  assign tb_end     = tb_run & (tb_cnt_ff == tb_len_ff - 1'b1);
  // wrap and restart every period, flag state does not matter
  assign nxt_tb_cnt = tb_end ? '0 : (tb_run ? tb_cnt_ff + 1'b1 : tb_cnt_ff);
  // the running length is only reloaded at a period boundary
  assign nxt_tb_len = tb_end ? sel_len : tb_len_ff;

  // -----------------------------------------------------------------------------
  // control/status register next value
  // -----------------------------------------------------------------------------
  always_comb begin
    nxt_ccs = ccs_ff;
    if (wr_ok) begin
      // flag bit is read only, writable bits under the mask
      nxt_ccs = ccs_t'((wr_byte & `CCS_WMASK) | (ccs_bits & ~`CCS_WMASK));
    end
    if (rd_clr) begin
      nxt_ccs.tick_flag = 1'b0;
    end
    if (tb_end) begin
      // hardware set wins over a read clear in the same cycle
      nxt_ccs.tick_flag = 1'b1;
    end
  end

  // -----------------------------------------------------------------------------
  // power mode sequencing
  // -----------------------------------------------------------------------------
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      PM_RUN: begin
        if (HALT_REQ & ccs_ff.tick_irq_enable & ~AWU_SEL) begin
          nxt_mode = PM_ACTIVE_HALT;
        end else if (HALT_REQ) begin
          nxt_mode = PM_HALT;
        end else if (WAIT_REQ) begin
          nxt_mode = PM_WAIT;
        end
      end
      PM_WAIT: begin
        if (irq_ff | EXT_WAKE) begin
          nxt_mode = PM_RUN;
        end
      end
      PM_ACTIVE_HALT: begin
        if (irq_ff | EXT_WAKE) begin
          nxt_mode = PM_RUN;
        end
      end
      PM_HALT: begin
        // the tick cannot end this mode, only another wake source
        if (EXT_WAKE) begin
          nxt_mode = PM_RUN;
        end
      end
    endcase
  end

  // core clock runs except in both halt modes
  assign core_run = regs_live;

  // -----------------------------------------------------------------------------
  // core clock prescaler
  // -----------------------------------------------------------------------------
  core_clk_div u_div (
    .clk     (SYS_CLK),
    .rst     (RST),
    .ce      (CE),
    .run     (core_run),
    .slow    (ccs_ff.slow_speed_select),
    .div_sel (ccs_ff.slow_divider_select),
    .core_en (core_en)
  );

  // -----------------------------------------------------------------------------
  // state registers
  // -----------------------------------------------------------------------------
  // control register and mode
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ccs_ff  <= ccs_t'(`CCS_RESET);
      mode_ff <= PM_RUN;
    end else if (CE) begin
      ccs_ff  <= nxt_ccs;
      mode_ff <= nxt_mode;
    end
  end

  // time-base counter, starts with the shortest period
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      tb_cnt_ff <= '0;
      tb_len_ff <= PERIOD_00;
    end else if (CE) begin
      tb_cnt_ff <= nxt_tb_cnt;
      tb_len_ff <= nxt_tb_len;
    end
  end

  // apb answer: ready one cycle after setup, no wait state
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= `APB_RDATA_ZERO;
    end else if (CE) begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~hit;
      prdata_ff  <= nxt_prdata;
    end
  end

  // interrupt and clock-out select outputs
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      irq_ff    <= 1'b0;
      clkout_ff <= 1'b0;
    end else if (CE) begin
      irq_ff    <= nxt_ccs.tick_flag & nxt_ccs.tick_irq_enable;
      clkout_ff <= nxt_ccs.clock_out_enable;
    end
  end

  // -----------------------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------------------
  assign PRDATA      = prdata_ff;
  assign PREADY      = pready_ff;
  assign PSLVERR     = pslverr_ff;
  assign TICK_IRQ    = irq_ff;
  assign CLKOUT_SEL  = clkout_ff;
  assign CORE_CLK_EN = core_en;
  assign PWR_MODE    = mode_ff;

endmodule // clock_prescaler_rtc_tick

// ===== clkctl_sva.sv
// port checker of the clock controller
`timescale 1ns/1ps
module clkctl_sva (
  input wire logic                  SYS_CLK,     // clock
  input wire logic                  RST,         // reset
  input wire logic                  CE,          // enable
  input wire logic                  PSEL,        // select
  input wire logic                  PENABLE,     // access
  input wire logic                  PWRITE,      // write
  input wire logic [31:0]           PWDATA,      // data
  input wire logic                  PREADY,      // ready
  input wire logic                  PSLVERR,     // error
  input wire logic                  EXT_WAKE,    // wake
  input wire logic                  CORE_CLK_EN, // core enable
  input wire logic                  CLKOUT_SEL,  // pin select
  input wire logic                  TICK_IRQ,    // request
  input wire clkctl_pkg::pwr_mode_t PWR_MODE     // mode
);
  import clkctl_pkg::*;
  // ------------------------------------------------------------
  // relations at the ports
  // ------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // helper terms: written bit, landed write, mode groups
  wire logic pw7 = PWDATA[7];
  wire logic wr  = PSEL && PENABLE && PREADY && CE && PWRITE && !PSLVERR;
  wire logic up  = (PWR_MODE == PM_RUN) || (PWR_MODE == PM_WAIT);
  wire logic ah  = (PWR_MODE == PM_ACTIVE_HALT);
  wire logic hl  = (PWR_MODE == PM_HALT);
  property p_clkout; wr && up |=> CLKOUT_SEL == $past(pw7); endproperty
  a_clkout: assert property (p_clkout) else $error("clkout wrong");
  property p_hold; TICK_IRQ && CE && !(PSEL && PENABLE) |=> TICK_IRQ; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped");
  property p_wwake; CE && TICK_IRQ && PWR_MODE == PM_WAIT |=> PWR_MODE == PM_RUN; endproperty
  a_wwake: assert property (p_wwake) else $error("no wait exit");
  property p_awake; CE && TICK_IRQ && ah |=> PWR_MODE == PM_RUN; endproperty
  a_awake: assert property (p_awake) else $error("no halt exit");
  property p_aclk; ah [*2] |-> !CORE_CLK_EN; endproperty
  a_aclk: assert property (p_aclk) else $error("core clock in halt");
  property p_hstay; hl && !EXT_WAKE |=> hl; endproperty
  a_hstay: assert property (p_hstay) else $error("halt left");
  property p_hfrz; hl |=> $stable(TICK_IRQ) && $stable(CLKOUT_SEL); endproperty
  a_hfrz: assert property (p_hfrz) else $error("halt not frozen");
  property p_rst; $fell(RST) |-> PWR_MODE == PM_RUN && !TICK_IRQ && !CLKOUT_SEL; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule // clkctl_sva

bind clock_prescaler_rtc_tick clkctl_sva clkctl_sva_i (
  .SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .EXT_WAKE(EXT_WAKE), .CORE_CLK_EN(CORE_CLK_EN), .CLKOUT_SEL(CLKOUT_SEL),
  .TICK_IRQ(TICK_IRQ), .PWR_MODE(PWR_MODE));

// ===== core_partner.sv
// core side model: runs wait and halt, counts core clocks
`timescale 1ns/1ps
module core_partner (
  input  wire logic clk,      // oscillator clock
  input  wire logic core_en,  // core clock enable
  output logic      wait_req, // wait executed
  output logic      halt_req, // halt executed
  output logic      awu_sel,  // auto-wake halt
  output int        n_en      // core clocks seen
);
  // ------------------------------------------------------------
  // core behaviour
  // ------------------------------------------------------------
  initial begin
    wait_req = 1'b0;
    halt_req = 1'b0;
    awu_sel = 1'b0;
  end
  // peripherals see every core clock
  always @(posedge clk) n_en <= n_en + (core_en ? 1 : 0);
  // an instruction only completes on a core clock edge
  task automatic issue(input logic h, input logic a);
    do @(posedge clk); while (!core_en);
    wait_req <= !h;
    halt_req <= h;
    awu_sel <= a;
    @(posedge clk);
    wait_req <= 1'b0;
    halt_req <= 1'b0;
  endtask
endmodule // core_partner

// ===== tb_top.sv
// self-checking bench of the clock controller with a reference model
`timescale 1ns/1ps
module tb_top;
  import clkctl_pkg::*;
  // ------------------------------------------------------------
  // stimulus, model state, design
  // ------------------------------------------------------------
  localparam int PT[4] = '{16, 32, 80, 200}; // shortened periods
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wake = 1'b0;
  logic        ce = 1'b1;
  apb_req_t    rq = '0;
  logic [31:0] prdata;
  logic        pready, pslverr, cen, wreq, hreq, awu, clko, irq;
  pwr_mode_t   mode, m_md;
  logic [7:0]  m_r, m_cap;
  int          cnt, per, n0, n_en, mismatches = 0, checks = 0;
  always #5 clk = ~clk;
  clock_prescaler_rtc_tick #(.PERIOD_00(18'(PT[0])), .PERIOD_01(18'(PT[1])),
    .PERIOD_10(18'(PT[2])), .PERIOD_11(18'(PT[3]))) clock_prescaler_rtc_tick_i (
    .SYS_CLK(clk), .RST(rst), .CE(ce), .PSEL(rq.psel), .PENABLE(rq.penable),
    .PWRITE(rq.pwrite), .PADDR(rq.paddr), .PWDATA(rq.pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .WAIT_REQ(wreq), .HALT_REQ(hreq), .AWU_SEL(awu),
    .EXT_WAKE(wake), .CORE_CLK_EN(cen), .CLKOUT_SEL(clko), .TICK_IRQ(irq), .PWR_MODE(mode));
  core_partner core_partner_i (.clk(clk), .core_en(cen), .wait_req(wreq), .halt_req(hreq),
    .awu_sel(awu), .n_en(n_en));
  task automatic bad(input string s);
    mismatches++;
    $display("BAD %0t %s", $time, s);
  endtask
  task automatic chk(input logic ok, input string s);
    checks++;
    if (!ok) bad(s);
  endtask
  // reference model: time base, register, power mode
  always @(posedge clk or posedge rst) begin : model
    logic tk, acc, ti;
    if (rst) begin
      m_r <= 8'h00;
      m_cap <= 8'h00;
      cnt <= 0;
      per <= PT[0];
      m_md <= PM_RUN;
    end else begin
      ti = m_r[0] & m_r[1];
      chk({irq, clko, mode} === {ti, m_r[7], m_md}, "status");
      // clock enable low freezes the whole model like the design
      if (ce) begin
        tk = m_md != PM_HALT && cnt + 1 == per;
        acc = rq.psel && rq.penable && rq.paddr == 12'h0B8 && !m_md[1];
        // read data is the register as it stood in the setup cycle
        if (rq.psel && !rq.penable) m_cap <= m_r;
        if (m_md != PM_HALT) cnt <= tk ? 0 : cnt + 1;
        if (tk) per <= PT[m_r[3:2]];
        if (acc && rq.pwrite) m_r[7:1] <= rq.pwdata[7:1];
        // only a flag that the read returned is cleared, a new tick wins
        m_r[0] <= tk || (m_r[0] && !(acc && !rq.pwrite && m_cap[0]));
        case (m_md)
          PM_RUN: if (wreq) m_md <= PM_WAIT;
            else if (hreq) m_md <= (m_r[1] && !awu) ? PM_ACTIVE_HALT : PM_HALT;
          PM_HALT: if (wake) m_md <= PM_RUN;
          default: if (ti || wake) m_md <= PM_RUN;
        endcase
      end
    end
  end
  // one apb transfer, checked at the ready edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    rq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'($urandom), d}};
    @(posedge clk);
    rq.penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    chk(pready === 1'b1 && pslverr === (a != 12'h0B8), "response");
    if (!w) chk(prdata === (a == 12'h0B8 ? {24'h0, m_cap} : 32'h0), "read");
    rq.psel <= 1'b0;
    rq.penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] d); apb(12'h0B8, 1'b1, d); endtask
  task automatic rd; apb(12'h0B8, 1'b0, 8'h00); endtask
  task automatic results;
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin : main
    int k;
    void'($urandom(32'hEBC9D016));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // cleared register, then unmapped places
    rd();
    for (k = 1; k < 4; k++) apb(12'h0B8 + 12'(4 * ($urandom % 8 + k)), k[0], 8'hFF);
    // core rate per divider code and normal speed, clock-out and tick alongside
    for (k = 0; k < 5; k++) begin
      wr({k[0], k[1:0], k < 4, 2'b00, 1'b1, 1'b0});
      repeat (20) @(posedge clk);
      n0 = n_en;
      repeat (64) @(posedge clk);
      chk(n_en - n0 == (k < 4 ? 64 >> (k + 1) : 64), "core rate");
    end
    // every period code, switched mid-period, read at random moments
    for (k = 0; k < 4; k++) begin
      wr({4'h0, k[1:0], 2'b10});
      repeat (6) begin
        repeat ($urandom % PT[k]) @(posedge clk);
        rd();
      end
    end
    // clock enable low freezes counter, register and outputs
    ce <= 1'b0;
    repeat (20 + $urandom % 200) @(posedge clk);
    ce <= 1'b1;
    // wait exits on tick; active halt counts, ignores writes and read-clear
    rd();
    core_partner_i.issue(1'b0, 1'b0);
    repeat (220) @(posedge clk);
    rd();
    core_partner_i.issue(1'b1, 1'b0);
    wr(8'h82);
    rd();
    repeat (220) @(posedge clk);
    // halt by auto-wake select, then with ticks off; only the other source wakes
    for (k = 0; k < 2; k++) begin
      wr({6'h00, !k[0], 1'b0});
      core_partner_i.issue(1'b1, !k[0]);
      repeat (300) @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      repeat (5) @(posedge clk);
    end
    // reset in mid-run
    wr(8'hFE);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd();
    results();
  end
  // hang guard
  initial begin : watchdog
    #200us;
    bad("timeout");
    results();
  end
endmodule // tb_top
